// ---- rtl/memmap_map.svh ----
// address map constants for the memory address decode block
`ifndef MEMMAP_MAP_SVH
`define MEMMAP_MAP_SVH
`define PA_RESET_ADDR     24'h000000
`define PA_RESET_TARGET   24'h000002
`define PA_VEC_END        24'h000200
`define PA_IVT_LO         24'h000004
`define PA_IVT_HI         24'h0000ff
`define PA_AIVT_LO        24'h000100
`define PA_AIVT_HI        24'h0001ff
`define PA_USER_TOP       24'h7ffffe
`define PA_CFG_BASE       24'hf80000
`define PA_CFG_END        24'hf80017
`define PA_IDENT_BASE     24'hff0000
`define PA_IDENT_END      24'hff0003
`define PA_STEP           24'h000002
`define PAGE_CFG_BIT      7
`define DA_CTL_END        16'h07ff
`define DA_NEAR_END       16'h1fff
`define DA_PSV_BIT        15
`define DA_WIN_BIT        15
`define DA_BYTE_STEP      16'h0001
`define DA_WORD_STEP      16'h0002
`endif

// ---- rtl/memmap_pkg.sv ----
// types shared by the memory address decode block
package memmap_pkg;
  // program space region classes
  typedef enum logic [2:0] {
    REG_VECTOR   = 3'h0,
    REG_USER     = 3'h1,
    REG_UNIMPL   = 3'h3,
    REG_CONFIG   = 3'h2,
    REG_IDENT    = 3'h6,
    REG_DENIED   = 3'h7
  } pregion_t;
  // program counter control
  typedef enum logic [1:0] {
    PC_HOLD = 2'h0,
    PC_INC  = 2'h1,
    PC_DEC  = 2'h3,
    PC_LOAD = 2'h2
  } pcop_t;
  // failing access kind recorded with a trap
  typedef enum logic [1:0] {
    FAIL_NONE  = 2'h0,
    FAIL_READ  = 2'h1,
    FAIL_WRITE = 2'h3
  } failkind_t;
  // trap sequencer
  typedef enum logic [1:0] {
    TR_IDLE = 2'h0,
    TR_HOLD = 2'h1,
    TR_REQ  = 2'h3
  } trap_state_t;
endpackage

// ---- rtl/data_ram.sv ----
// byte-lane data memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module data_ram #(
  parameter int AW = 12
) (
  input  wire logic          clk,
  input  wire logic [AW-1:0] raddr,
  input  wire logic [AW-1:0] waddr,
  input  wire logic          we_lo,
  input  wire logic          we_hi,
  input  wire logic [15:0]   wdata,
  output logic      [15:0]   rdata
);
  logic [7:0] mem_lo [2**AW]; // even byte lane
  logic [7:0] mem_hi [2**AW]; // odd byte lane
  // separate write lines on a shared word decode
  always_ff @(posedge clk) begin
    if (we_lo) begin
      mem_lo[waddr] <= wdata[7:0];
    end
    if (we_hi) begin
      mem_hi[waddr] <= wdata[15:8];
    end
    rdata <= {mem_hi[raddr], mem_lo[raddr]};
  end
endmodule
`default_nettype wire

// ---- rtl/prog_decode.sv ----
// classifies a 24-bit program address into its region
`timescale 1ns/1ns
`default_nettype none
`include "memmap_map.svh"
module prog_decode #(
  parameter logic [23:0] FLASH_END = 24'h0157fe
) (
  input  wire logic [23:0]         addr,
  input  wire logic                table_op,
  input  wire logic [7:0]          page,
  output memmap_pkg::pregion_t     region
);
  // config space needs a table op with the page bit set
  always_comb begin
    if (!addr[23]) begin
      if (addr < `PA_VEC_END) begin
        region = memmap_pkg::REG_VECTOR;
      end else if (addr <= FLASH_END) begin
        region = memmap_pkg::REG_USER;
      end else begin
        region = memmap_pkg::REG_UNIMPL;
      end
    end else if (!(table_op && page[`PAGE_CFG_BIT])) begin
      region = memmap_pkg::REG_DENIED;
    end else if (addr >= `PA_CFG_BASE && addr <= `PA_CFG_END) begin
      region = memmap_pkg::REG_CONFIG;
    end else if (addr >= `PA_IDENT_BASE && addr <= `PA_IDENT_END) begin
      region = memmap_pkg::REG_IDENT;
    end else begin
      region = memmap_pkg::REG_DENIED;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/memmap_core.sv ----
// program and data address map, byte lanes and address error trap
`timescale 1ns/1ns
`default_nettype none
`include "memmap_map.svh"
module memmap_core #(
  parameter int          DATA_BYTES = 8192,
  parameter logic [23:0] FLASH_END  = 24'h0157fe,
  parameter logic [23:0] IDENT_WORD = 24'h00a5a5 // arbitrary value
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  // program counter control
  input  wire logic [1:0]  PC_OP,
  input  wire logic [22:0] PC_LOAD_VAL,
  output logic      [23:0] PC_ADDR,
  // table access to program space
  input  wire logic        TBL_REQ,
  input  wire logic        TBL_WRITE,
  input  wire logic [7:0]  TABLE_PAGE_SELECT,
  input  wire logic [15:0] TBL_OFFSET,
  input  wire logic [23:0] PROG_RDATA,
  output logic      [23:0] TBL_RDATA,
  output logic             TBL_DENIED,
  output logic      [2:0]  TBL_REGION,
  output logic             VEC_PRIMARY,
  output logic             VEC_ALTERNATE,
  // data read generator
  input  wire logic        RD_REQ,
  input  wire logic        RD_BYTE,
  input  wire logic        RD_NEAR,
  input  wire logic [15:0] RD_PTR,
  input  wire logic [15:0] CTL_RDATA,
  input  wire logic        CTL_HIT,
  input  wire logic [1:0]  RD_EXT,
  input  wire logic [15:0] WORKING_REG_SOURCE,
  output logic      [15:0] RD_DATA,
  output logic      [15:0] RD_PTR_NEXT,
  output logic             RD_VALID,
  output logic             RD_PSV,
  output logic             RD_CTL,
  // data write generator
  input  wire logic        WR_REQ,
  input  wire logic        WR_BYTE,
  input  wire logic [15:0] WR_PTR,
  input  wire logic [15:0] WR_DATA,
  output logic      [15:0] WR_PTR_NEXT,
  output logic             CTL_WE_LO,
  output logic             CTL_WE_HI,
  output logic      [15:0] CTL_WADDR,
  output logic      [15:0] CTL_WDATA,
  // instruction boundary and trap
  input  wire logic        INSN_DONE,
  input  wire logic        TRAP_ACK,
  output logic             ADDR_TRAP,
  output logic      [1:0]  FAIL_KIND
);
  localparam int RAW = $clog2(DATA_BYTES) - 1; // word address width

  typedef struct packed {
    logic [22:0]              pc;
    logic [23:0]              tbl_rdata;
    logic                     tbl_denied;
    logic [2:0]               tbl_region;
    logic                     vec_pri;
    logic                     vec_alt;
    logic [15:0]              rd_ptr_next;
    logic                     rd_valid;
    logic                     rd_psv;
    logic                     rd_ctl;
    logic                     rd_byte;
    logic                     rd_hi;
    logic                     rd_zero;
    logic                     rd_from_ctl;
    logic [15:0]              ctl_rd;
    logic [1:0]               rd_ext;
    logic [15:0]              wreg;
    logic [15:0]              wr_ptr_next;
    logic                     ctl_we_lo;
    logic                     ctl_we_hi;
    logic [15:0]              ctl_waddr;
    logic [15:0]              ctl_wdata;
    memmap_pkg::trap_state_t  trap;
    logic                     trap_req;
    memmap_pkg::failkind_t    fail;
  } state_t;

  state_t st_ff;   // registered state
  state_t nxt_st;  // next state

  // shared decode results
  logic [23:0]          tbl_addr;     // page joined to offset
  memmap_pkg::pregion_t tbl_reg;      // region of the table address
  logic [15:0]          rd_adr;       // read address after near masking
  logic                 rd_mis;       // odd word read
  logic                 wr_mis;       // odd word write
  logic                 rd_in_ram;    // read hits implemented memory
  logic                 wr_in_ram;    // write hits implemented memory
  logic                 rd_is_ctl;    // read falls in control window
  logic                 wr_is_ctl;    // write falls in control window
  logic                 ram_we_lo;    // lane strobes toward the array
  logic                 ram_we_hi;
  logic [15:0]          ram_rdata;    // registered array read word
  logic [15:0]          word;         // selected raw word
  logic [7:0]           lane;         // selected byte
  logic [15:0]          rd_out;       // final read result

  // table address: page supplies bits 23:16
  assign tbl_addr = {TABLE_PAGE_SELECT, TBL_OFFSET};

  prog_decode #(
    .FLASH_END (FLASH_END)
  ) u_pdec (
    .addr     (tbl_addr),
    .table_op (TBL_REQ),
    .page     (TABLE_PAGE_SELECT),
    .region   (tbl_reg)
  );

  // near instructions carry only 13 address bits
  assign rd_adr = RD_NEAR ? {3'h0, RD_PTR[12:0]} : RD_PTR;
  assign rd_mis = RD_REQ && !RD_BYTE && rd_adr[0];
  assign wr_mis = WR_REQ && !WR_BYTE && WR_PTR[0];
  assign rd_is_ctl = rd_adr <= `DA_CTL_END;
  assign wr_is_ctl = WR_PTR <= `DA_CTL_END;
  // top bit set means visibility window, not array
  assign rd_in_ram = !rd_adr[`DA_PSV_BIT] && !rd_is_ctl &&
                     (32'(rd_adr) < DATA_BYTES);
  assign wr_in_ram = !WR_PTR[`DA_WIN_BIT] && !wr_is_ctl &&
                     (32'(WR_PTR) < DATA_BYTES);
  // misaligned writes never reach a lane
  assign ram_we_lo = WR_REQ && wr_in_ram && !wr_mis &&
                     (!WR_BYTE || !WR_PTR[0]);
  assign ram_we_hi = WR_REQ && wr_in_ram && !wr_mis &&
                     (!WR_BYTE || WR_PTR[0]);

  data_ram #(
    .AW (RAW)
  ) u_ram (
    .clk   (CLK),
    .raddr (rd_adr[RAW:1]),
    .waddr (WR_PTR[RAW:1]),
    .we_lo (ram_we_lo),
    .we_hi (ram_we_hi),
    .wdata (WR_BYTE ? {WR_DATA[7:0], WR_DATA[7:0]} : WR_DATA),
    .rdata (ram_rdata)
  );

  // read data path, one cycle behind the request
  always_comb begin
    word = st_ff.rd_zero ? 16'h0000 :
           (st_ff.rd_from_ctl ? st_ff.ctl_rd : ram_rdata);
    lane = st_ff.rd_hi ? word[15:8] : word[7:0];
    if (!st_ff.rd_byte) begin
      rd_out = word;
    end else begin
      case (st_ff.rd_ext)
        2'h1: rd_out = {{8{lane[7]}}, lane};
        2'h2: rd_out = {8'h00, lane};
        2'h3: rd_out = {st_ff.wreg[15:8], lane};
        default: rd_out = {8'h00, lane};
      endcase
    end
  end

  // next-state logic for every field of the st_ff state register
  always_comb begin
    nxt_st = st_ff;
    // program counter: always even, steps by two
    case (memmap_pkg::pcop_t'(PC_OP))
      memmap_pkg::PC_INC:  nxt_st.pc = st_ff.pc + 23'(`PA_STEP);
      memmap_pkg::PC_DEC:  nxt_st.pc = st_ff.pc - 23'(`PA_STEP);
      memmap_pkg::PC_LOAD: nxt_st.pc = {PC_LOAD_VAL[22:1], 1'b0};
      default:             nxt_st.pc = st_ff.pc;
    endcase
    // table read into program space
    if (TBL_REQ) begin
      nxt_st.tbl_region = tbl_reg;
      nxt_st.tbl_denied = tbl_reg == memmap_pkg::REG_DENIED;
      nxt_st.vec_pri = tbl_addr >= `PA_IVT_LO &&
                       tbl_addr <= `PA_IVT_HI;
      nxt_st.vec_alt = tbl_addr >= `PA_AIVT_LO &&
                       tbl_addr <= `PA_AIVT_HI;
      case (tbl_reg)
        memmap_pkg::REG_VECTOR,
        memmap_pkg::REG_USER:   nxt_st.tbl_rdata = PROG_RDATA;
        memmap_pkg::REG_CONFIG: nxt_st.tbl_rdata = PROG_RDATA;
        // upper byte of odd word unimplemented
        memmap_pkg::REG_IDENT:  nxt_st.tbl_rdata = IDENT_WORD;
        memmap_pkg::REG_UNIMPL: nxt_st.tbl_rdata = 24'h000000;
        default:                nxt_st.tbl_rdata = 24'h000000;
      endcase
      if (TBL_WRITE || tbl_addr[0]) begin
        nxt_st.tbl_rdata[23:16] = 8'h00;
      end
    end
    // read generator
    nxt_st.rd_valid = RD_REQ;
    nxt_st.rd_byte = RD_BYTE;
    nxt_st.rd_hi = rd_adr[0];
    nxt_st.rd_psv = RD_REQ && rd_adr[`DA_PSV_BIT];
    nxt_st.rd_ctl = RD_REQ && rd_is_ctl;
    nxt_st.rd_from_ctl = rd_is_ctl;
    nxt_st.ctl_rd = CTL_HIT ? CTL_RDATA : 16'h0000;
    nxt_st.rd_zero = !rd_is_ctl && !rd_in_ram;
    nxt_st.rd_ext = RD_EXT;
    nxt_st.wreg = WORKING_REG_SOURCE;
    if (RD_REQ) begin
      nxt_st.rd_ptr_next = RD_PTR + (RD_BYTE ? `DA_BYTE_STEP :
                                               `DA_WORD_STEP);
    end
    // write generator
    nxt_st.ctl_we_lo = WR_REQ && wr_is_ctl && !wr_mis &&
                       (!WR_BYTE || !WR_PTR[0]);
    nxt_st.ctl_we_hi = WR_REQ && wr_is_ctl && !wr_mis &&
                       (!WR_BYTE || WR_PTR[0]);
    nxt_st.ctl_waddr = {WR_PTR[15:1], 1'b0};
    nxt_st.ctl_wdata = WR_BYTE ? {WR_DATA[7:0], WR_DATA[7:0]} : WR_DATA;
    if (WR_REQ) begin
      nxt_st.wr_ptr_next = WR_PTR + (WR_BYTE ? `DA_BYTE_STEP :
                                               `DA_WORD_STEP);
    end
    // trap sequencer: catch, wait for instruction end, request
    case (st_ff.trap)
      memmap_pkg::TR_IDLE: begin
        if (rd_mis || wr_mis) begin
          nxt_st.fail = wr_mis ? memmap_pkg::FAIL_WRITE
                               : memmap_pkg::FAIL_READ;
          nxt_st.trap = INSN_DONE ? memmap_pkg::TR_REQ
                                  : memmap_pkg::TR_HOLD;
        end
      end
      memmap_pkg::TR_HOLD: begin
        // instruction still running; trap waits
        if (INSN_DONE) begin
          nxt_st.trap = memmap_pkg::TR_REQ;
        end
      end
      memmap_pkg::TR_REQ: begin
        // held until exception logic takes it
        if (TRAP_ACK) begin
          nxt_st.trap = memmap_pkg::TR_IDLE;
          nxt_st.fail = memmap_pkg::FAIL_NONE;
        end
      end
      default: nxt_st.trap = memmap_pkg::TR_IDLE;
    endcase
    nxt_st.trap_req = nxt_st.trap == memmap_pkg::TR_REQ;
  end

  // clocked process for st_ff; reset puts pc at the jump slot
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // registered read data, aligned with rd_valid
  logic [15:0] rd_data_ff; // final read word
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rd_data_ff <= 16'h0000;
    end else begin
      rd_data_ff <= rd_out;
    end
  end
  logic rd_valid_ff; // one cycle after the array
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= st_ff.rd_valid;
    end
  end

  // outputs straight from flip-flops
  assign PC_ADDR       = {1'b0, st_ff.pc};
  assign TBL_RDATA     = st_ff.tbl_rdata;
  assign TBL_DENIED    = st_ff.tbl_denied;
  assign TBL_REGION    = st_ff.tbl_region;
  assign VEC_PRIMARY   = st_ff.vec_pri;
  assign VEC_ALTERNATE = st_ff.vec_alt;
  assign RD_DATA       = rd_data_ff;
  assign RD_VALID      = rd_valid_ff;
  assign RD_PTR_NEXT   = st_ff.rd_ptr_next;
  assign RD_PSV        = st_ff.rd_psv;
  assign RD_CTL        = st_ff.rd_ctl;
  assign WR_PTR_NEXT   = st_ff.wr_ptr_next;
  assign CTL_WE_LO     = st_ff.ctl_we_lo;
  assign CTL_WE_HI     = st_ff.ctl_we_hi;
  assign CTL_WADDR     = st_ff.ctl_waddr;
  assign CTL_WDATA     = st_ff.ctl_wdata;
  assign ADDR_TRAP     = st_ff.trap_req;
  assign FAIL_KIND     = st_ff.fail;

  // checks
  sequence s_mis_cause;
    (RD_REQ && !RD_BYTE && rd_adr[0]) || (WR_REQ && !WR_BYTE && WR_PTR[0]);
  endsequence
  sequence s_done;
    INSN_DONE;
  endsequence

  chk_mis_trap_raise: assert property (@(posedge CLK) disable iff (RST)
    (s_mis_cause and s_done) and (st_ff.trap == memmap_pkg::TR_IDLE)
    |=> ADDR_TRAP) else $error("misaligned access gave no trap");
  chk_trap_held: assert property (@(posedge CLK) disable iff (RST)
    ADDR_TRAP && !TRAP_ACK |=> ADDR_TRAP)
    else $error("trap request dropped before ack");
  chk_trap_waits: assert property (@(posedge CLK) disable iff (RST)
    st_ff.trap == memmap_pkg::TR_HOLD && !INSN_DONE |=> !ADDR_TRAP)
    else $error("trap raised before instruction end");
  chk_mis_wr_block: assert property (@(posedge CLK) disable iff (RST)
    WR_REQ && !WR_BYTE && WR_PTR[0] |-> !ram_we_lo && !ram_we_hi
    ##1 !CTL_WE_LO && !CTL_WE_HI)
    else $error("misaligned write reached memory");
  chk_byte_lane: assert property (@(posedge CLK) disable iff (RST)
    WR_REQ && WR_BYTE && !WR_PTR[0] |-> !ram_we_hi)
    else $error("even byte write hit high lane");
  chk_ptr_step: assert property (@(posedge CLK) disable iff (RST)
    RD_REQ |=> RD_PTR_NEXT == $past(RD_PTR) + ($past(RD_BYTE) ? 16'h0001
                                                    : 16'h0002))
    else $error("read pointer step wrong");
  chk_pc_even: assert property (@(posedge CLK) disable iff (RST)
    PC_OP == 2'h1 |=> PC_ADDR == $past(PC_ADDR) + 24'h000002)
    else $error("program counter step wrong");
  chk_psv_zero: assert property (@(posedge CLK) disable iff (RST)
    RD_REQ && rd_adr[15] |=> ##1 RD_VALID && (RD_DATA[7:0] == 8'h00 ||
    $past(RD_EXT,2) == 2'h3))
    else $error("window read not zero");
  chk_cfg_denied: assert property (@(posedge CLK) disable iff (RST)
    TBL_REQ && TABLE_PAGE_SELECT == 8'h80 && TBL_OFFSET == 16'h0000
    |=> TBL_DENIED)
    else $error("reserved upper space not refused");
  chk_unimpl_zero: assert property (@(posedge CLK) disable iff (RST)
    TBL_REQ && tbl_reg == memmap_pkg::REG_UNIMPL |=> TBL_RDATA == 24'h0)
    else $error("unimplemented flash read not zero");
endmodule
`default_nettype wire

// ---- verification/ctl_side_model.sv ----
// far-side model: control-register window and program flash words
`timescale 1ns/1ns
`default_nettype none
module ctl_side_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_ptr,
  input  wire logic [15:0] tbl_off,
  input  wire logic        we_lo,
  input  wire logic        we_hi,
  input  wire logic [15:0] waddr,
  input  wire logic [15:0] wdata,
  output logic      [23:0] prog_rdata,
  output logic      [15:0] ctl_rdata,
  output logic             ctl_hit
);
  logic [15:0] regs [4]; // four implemented words at 0x0020..0x0027
  logic [15:0] last;     // last value shown on the read lines
  logic        rd_win;   // read falls on an implemented word
  logic        wr_win;   // write falls on an implemented word
  // the rest of the control window is unused and never answers
  assign rd_win = (rd_ptr[15:3] == 13'h0004);
  assign wr_win = (waddr[15:3] == 13'h0004);
  assign ctl_hit = rd_req && rd_win;
  // idle lines show the inverse of the last value, never a stale copy
  assign ctl_rdata = ctl_hit ? regs[rd_ptr[2:1]] : ~last;
  // fixed top byte shows whether the unimplemented byte is dropped
  assign prog_rdata = {8'hc3, tbl_off};
  // register file with separate byte lanes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        regs[i] <= {8'h4c, 8'(i)};
      end
      last <= 16'h0000;
    end else begin
      if (ctl_hit) begin
        last <= ctl_rdata;
      end
      if (we_lo && wr_win) begin
        regs[waddr[2:1]][7:0] <= wdata[7:0];
      end
      if (we_hi && wr_win) begin
        regs[waddr[2:1]][15:8] <= wdata[15:8];
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking testbench for the memory address decode block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        clk, rst, tbl_req, tbl_wr, tbl_den, vec_p, vec_a;
  logic        rd_req, rd_byte, rd_near, ctl_hit, rd_valid, rd_psv, rd_ctl;
  logic        wr_req, wr_byte, we_lo, we_hi, insn_done, trap_ack, trap;
  logic        got_psv, got_ctl, got_lo, got_hi;
  logic [1:0]  pc_op, rd_ext, fail_kind;
  logic [2:0]  tbl_reg;
  logic [7:0]  page;
  logic [22:0] pc_val;
  logic [23:0] pc_addr, prog_rdata, tbl_rdata;
  logic [15:0] tbl_off, rd_ptr, ctl_rdata, wrs, rd_data, rd_nxt;
  logic [15:0] wr_ptr, wr_data, wr_nxt, ctl_waddr, ctl_wdata, got_waddr;
  int          n_mismatch, tests_run;

  memmap_core i_dut (.CLK(clk), .RST(rst), .PC_OP(pc_op),
    .PC_LOAD_VAL(pc_val), .PC_ADDR(pc_addr), .TBL_REQ(tbl_req),
    .TBL_WRITE(tbl_wr), .TABLE_PAGE_SELECT(page), .TBL_OFFSET(tbl_off),
    .PROG_RDATA(prog_rdata), .TBL_RDATA(tbl_rdata), .TBL_DENIED(tbl_den),
    .TBL_REGION(tbl_reg), .VEC_PRIMARY(vec_p), .VEC_ALTERNATE(vec_a),
    .RD_REQ(rd_req), .RD_BYTE(rd_byte), .RD_NEAR(rd_near),
    .RD_PTR(rd_ptr), .CTL_RDATA(ctl_rdata), .CTL_HIT(ctl_hit),
    .RD_EXT(rd_ext), .WORKING_REG_SOURCE(wrs), .RD_DATA(rd_data),
    .RD_PTR_NEXT(rd_nxt), .RD_VALID(rd_valid), .RD_PSV(rd_psv),
    .RD_CTL(rd_ctl), .WR_REQ(wr_req), .WR_BYTE(wr_byte), .WR_PTR(wr_ptr),
    .WR_DATA(wr_data), .WR_PTR_NEXT(wr_nxt), .CTL_WE_LO(we_lo),
    .CTL_WE_HI(we_hi), .CTL_WADDR(ctl_waddr), .CTL_WDATA(ctl_wdata),
    .INSN_DONE(insn_done), .TRAP_ACK(trap_ack), .ADDR_TRAP(trap),
    .FAIL_KIND(fail_kind));

  ctl_side_model i_far (.clk(clk), .rst(rst), .rd_req(rd_req),
    .rd_ptr(rd_ptr), .tbl_off(tbl_off), .we_lo(we_lo), .we_hi(we_hi),
    .waddr(ctl_waddr), .wdata(ctl_wdata), .prog_rdata(prog_rdata),
    .ctl_rdata(ctl_rdata), .ctl_hit(ctl_hit));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // compare one value, count it and report a difference
  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one table access; the answer stands until the next request
  task automatic tbl(input logic [23:0] a, input logic [2:0] reg_exp);
    @(negedge clk);
    tbl_req = 1'b1;
    page = a[23:16];
    tbl_off = a[15:0];
    @(negedge clk);
    tbl_req = 1'b0;
    @(negedge clk);
    check("tbl_region", {21'h0, reg_exp}, {21'h0, tbl_reg});
    check("tbl_denied", {23'h0, reg_exp == 3'(memmap_pkg::REG_DENIED)},
          {23'h0, tbl_den});
  endtask

  // one data read; pulses are gathered while waiting for valid
  task automatic rd(input logic [15:0] a, input logic b, input logic [1:0] x);
    @(negedge clk);
    rd_req = 1'b1;
    rd_ptr = a;
    rd_byte = b;
    rd_ext = x;
    @(negedge clk);
    rd_req = 1'b0;
    got_psv = rd_psv;
    got_ctl = rd_ctl;
    check("rd_early", 24'h0, {23'h0, rd_valid});
    @(negedge clk);
    check("rd_valid", 24'h1, {23'h0, rd_valid});
  endtask

  // one data write; strobes may show in either of two cycles
  task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d);
    @(negedge clk);
    wr_req = 1'b1;
    wr_ptr = a;
    wr_byte = b;
    wr_data = d;
    @(negedge clk);
    wr_req = 1'b0;
    got_lo = we_lo;
    got_hi = we_hi;
    got_waddr = ctl_waddr;
    @(negedge clk);
    if (we_lo | we_hi) begin
      got_waddr = ctl_waddr;
    end
    got_lo = got_lo | we_lo;
    got_hi = got_hi | we_hi;
  endtask

  // end the instruction, expect a held trap with its kind, then clear it
  task automatic trap_seq(input logic [1:0] kind);
    check("trap_early", 24'h0, {23'h0, trap});
    insn_done = 1'b1;
    @(negedge clk);
    insn_done = 1'b0;
    check("trap_raise", 24'h1, {23'h0, trap});
    check("fail_kind", {22'h0, kind}, {22'h0, fail_kind});
    repeat (3) @(negedge clk);
    check("trap_held", 24'h1, {23'h0, trap});
    trap_ack = 1'b1;
    @(negedge clk);
    trap_ack = 1'b0;
    repeat (2) @(negedge clk);
    check("trap_clear", 24'h0, {23'h0, trap});
  endtask

  // program counter: reset value, steps of two, load alignment
  task automatic t_pc;
    check("pc_reset", 24'h000000, pc_addr);
    pc_op = 2'(memmap_pkg::PC_INC);
    @(negedge clk);
    check("pc_inc", 24'h000002, pc_addr);
    pc_op = 2'(memmap_pkg::PC_DEC);
    @(negedge clk);
    check("pc_dec", 24'h000000, pc_addr);
    pc_val = 23'h7fffff;
    pc_op = 2'(memmap_pkg::PC_LOAD);
    @(negedge clk);
    check("pc_load", 24'h7ffffe, pc_addr);
    pc_op = 2'(memmap_pkg::PC_HOLD);
    @(negedge clk);
    check("pc_hold", 24'h7ffffe, pc_addr);
  endtask

  // program space regions reached by table reads
  task automatic t_table;
    tbl(24'h000000, 3'(memmap_pkg::REG_VECTOR));
    tbl(24'h000004, 3'(memmap_pkg::REG_VECTOR));
    check("vec_primary", 24'h1, {23'h0, vec_p});
    tbl(24'h000100, 3'(memmap_pkg::REG_VECTOR));
    check("vec_alternate", 24'h1, {23'h0, vec_a});
    tbl(24'h000200, 3'(memmap_pkg::REG_USER));
    check("tbl_even", 24'hc30200, tbl_rdata);
    tbl(24'h000201, 3'(memmap_pkg::REG_USER));
    check("tbl_odd", 24'h000201, tbl_rdata);
    tbl(24'h015800, 3'(memmap_pkg::REG_UNIMPL));
    check("tbl_unimpl", 24'h000000, tbl_rdata);
    tbl(24'h7ffffe, 3'(memmap_pkg::REG_UNIMPL));
    check("tbl_top", 24'h000000, tbl_rdata);
    tbl(24'hf80000, 3'(memmap_pkg::REG_CONFIG));
    tbl(24'hff0000, 3'(memmap_pkg::REG_IDENT));
    check("tbl_ident", 24'h00a5a5, tbl_rdata);
    tbl(24'h800000, 3'(memmap_pkg::REG_DENIED));
    check("tbl_refused", 24'h000000, tbl_rdata);
    tbl_wr = 1'b1;
    tbl(24'h000200, 3'(memmap_pkg::REG_USER));
    tbl_wr = 1'b0;
    check("tbl_write", 24'h000200, tbl_rdata);
  endtask

  // data memory: lanes, extension, range, near and window reads
  task automatic t_data;
    wr(16'h0800, 1'b0, 16'h1357);
    wr(16'h0802, 1'b0, 16'h2468);
    wr(16'h0803, 1'b1, 16'h00a9);
    check("wptr_byte", 24'h000804, {8'h0, wr_nxt});
    rd(16'h0800, 1'b0, 2'h0);
    check("rd_word", 24'h001357, {8'h0, rd_data});
    check("ptr_word", 24'h000802, {8'h0, rd_nxt});
    rd(16'h0802, 1'b0, 2'h0);
    check("rd_lane", 24'h00a968, {8'h0, rd_data});
    rd(16'h0803, 1'b1, 2'h0);
    check("rd_byte", 24'h0000a9, {8'h0, rd_data});
    check("ptr_byte", 24'h000804, {8'h0, rd_nxt});
    rd(16'h0803, 1'b1, 2'h1);
    check("rd_sign", 24'h00ffa9, {8'h0, rd_data});
    rd(16'h0803, 1'b1, 2'h2);
    check("rd_zero", 24'h0000a9, {8'h0, rd_data});
    wrs = 16'h5500;
    rd(16'h0802, 1'b1, 2'h3);
    check("rd_keep", 24'h005568, {8'h0, rd_data});
    rd(16'h2000, 1'b0, 2'h0);
    check("rd_outside", 24'h0, {8'h0, rd_data});
    rd_near = 1'b1;
    rd(16'he800, 1'b0, 2'h0);
    rd_near = 1'b0;
    check("rd_near", 24'h001357, {8'h0, rd_data});
    rd(16'h8000, 1'b0, 2'h0);
    check("rd_psv", 24'h1, {23'h0, got_psv});
  endtask

  // control-register window: hit, unused address, byte write strobe
  task automatic t_ctl;
    rd(16'h0022, 1'b0, 2'h0);
    check("ctl_read", 24'h004c01, {8'h0, rd_data});
    check("ctl_flag", 24'h1, {23'h0, got_ctl});
    rd(16'h0040, 1'b0, 2'h0);
    check("ctl_unused", 24'h0, {8'h0, rd_data});
    wr(16'h0023, 1'b1, 16'h00ab);
    check("we_pair", 24'h2, {22'h0, got_hi, got_lo});
    check("ctl_waddr", 24'h000022, {8'h0, got_waddr});
    rd(16'h0022, 1'b0, 2'h0);
    check("ctl_lane", 24'h00ab01, {8'h0, rd_data});
  endtask

  // misaligned word write then read, each trapped after the instruction
  task automatic t_trap;
    wr(16'h0801, 1'b0, 16'hbeef);
    check("no_strobe", 24'h0, {22'h0, got_hi, got_lo});
    trap_seq(2'(memmap_pkg::FAIL_WRITE));
    rd(16'h0800, 1'b0, 2'h0);
    check("write_dropped", 24'h001357, {8'h0, rd_data});
    rd(16'h0803, 1'b0, 2'h0);
    trap_seq(2'(memmap_pkg::FAIL_READ));
    // misaligned write in the instruction's last cycle traps at once
    insn_done = 1'b1;
    wr(16'h0805, 1'b0, 16'h1111);
    insn_done = 1'b0;
    check("trap_same", 24'h1, {23'h0, trap});
    check("fail_same", 24'h3, {22'h0, fail_kind});
    trap_ack = 1'b1;
    @(negedge clk);
    trap_ack = 1'b0;
    @(negedge clk);
    check("trap_gone", 24'h0, {23'h0, trap});
  endtask

  // report the counts and the verdict, then stop
  task automatic results;
    $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // cut a hang short well beyond the expected 120 or so cycles
  initial begin
    #(3000 * 100);
    n_mismatch++;
    results();
  end

  // main sequence
  initial begin
    {rst, tbl_req, tbl_wr, rd_req, rd_byte, rd_near} = 6'h20;
    {wr_req, wr_byte, insn_done, trap_ack} = 4'h0;
    {pc_op, rd_ext, page, pc_val} = 35'h0;
    {tbl_off, rd_ptr, wrs, wr_ptr, wr_data} = 80'h0;
    n_mismatch = 0;
    tests_run = 0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_pc();
    t_table();
    t_data();
    t_ctl();
    t_trap();
    results();
  end
endmodule
`default_nettype wire
